// ---- rtl/sfph_pkg.sv ----
// constants and types for the flash protect and hold block
package sfph_pkg;

  // ----------------------------------------
  // pin synchroniser slots
  // ----------------------------------------
  localparam int PIN_CNT = 5;
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_HOLD_N = 2;
  localparam int PIN_WP_N = 3;
  localparam int PIN_DIN = 4;

  // ----------------------------------------
  // array geometry and protection fields
  // ----------------------------------------
  localparam int SECTOR_CNT = 128;
  localparam int SECTOR_W = 7;
  localparam int BIT_CNT_W = 3;
  localparam int PROT_W = 3;
  localparam logic [2:0] PROT_NONE = 3'h0;
  localparam logic [2:0] PROT_ALL = 3'h7;
  localparam logic [7:0] RANGE_BASE = 8'h02;
  localparam logic [1:0] LOCK_RST = 2'h0;
  localparam logic [2:0] PROT_RST = 3'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int PUW_TIME_US = 1000;
  localparam int PUW_CYCLES = PUW_TIME_US * CLK_MHZ;
  localparam int PUW_CNT_W = 18;

  // ----------------------------------------
  // commands handed over by the decoder
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_WRITE_ARM,
    CMD_WRITE_DISARM,
    CMD_STATUS_STORE,
    CMD_LOCKREG_STORE,
    CMD_LOCKREG_FETCH,
    CMD_OTP_WRITE,
    CMD_PAGE_WRITE,
    CMD_PAGE_WRITE_TWO_LANE,
    CMD_BLOCK4K_WIPE,
    CMD_BLOCK64K_WIPE,
    CMD_FULL_ARRAY_WIPE,
    CMD_SLEEP,
    CMD_WAKE
  } sfph_cmd_e;

  // ----------------------------------------
  // hold states
  // ----------------------------------------
  typedef enum logic [1:0] {
    HS_RUN,
    HS_HOLD,
    HS_LOCKOUT
  } sfph_hold_e;

endpackage : sfph_pkg

// ---- rtl/sfph_top.sv ----
// write protection, lock registers and hold logic of the serial flash
`timescale 1ns/1ps

// Overview of operation
// - program, erase, status store run only after whole multiples of eight clocks
// - data-changing commands need the write arm latch set beforehand
// - arm latch clears at power-up and on completion of listed commands
// - modifying commands blocked until power-up wait timer expires
// - deep sleep ignores write, program and erase commands
// - each 64-Kbyte sector has a write-lock and a lock-down bit
// - write-locked sector rejects page writes and 4K/64K block wipes, not OTP write or full wipe
// - lock-down freezes both sector bits until next power-up
// - lock registers are fetched and stored by dedicated commands
// - sector protected if lock bit or range protects it
// - top mode codes protect highest 2..64 sectors, 7 all, 0 none
// - bottom mode codes protect lowest 2..64 sectors, 7 all, 0 none
// - full array wipe only with all prot_size bits zero
// - write-protect pin with freeze enable makes status read-only
// - hold pauses transfer, keeps bit count and running cycles
// - hold starts only while selected
// - hold begins on hold fall with clock low, else next clock low
// - hold ends on hold rise with clock low, else next clock low
// - during hold output floats and input and clock are ignored
// - deselect in hold resets interface; raise hold before reselecting
// - input sampled on rising clock, output driven from falling clock
// - deep sleep entered by sleep command, left only by wake command
module sfph_top #(
  parameter int PUW_CYCLES = sfph_pkg::PUW_CYCLES
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // serial pins
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic serial_in_pin,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n,
  // decoder side
  input wire logic cmd_valid,
  input wire sfph_pkg::sfph_cmd_e cmd_code,
  input wire logic [sfph_pkg::SECTOR_W-1:0] cmd_sector,
  input wire logic [1:0] lock_wdata,
  input wire logic [sfph_pkg::PROT_W-1:0] prot_size_wdata,
  input wire logic top_bottom_wdata,
  input wire logic freeze_wdata,
  input wire logic tx_bit,
  output logic rx_bit,
  output logic rx_strobe,
  // array engine side
  input wire logic op_done,
  output logic exec_go,
  output logic exec_refuse,
  output sfph_pkg::sfph_cmd_e exec_cmd,
  output logic [sfph_pkg::SECTOR_W-1:0] exec_sector,
  // status and lock readback
  output logic write_arm_latch,
  output logic op_busy,
  output logic deep_sleep,
  output logic powerup_done,
  output logic hold_active,
  output logic [sfph_pkg::PROT_W-1:0] prot_size,
  output logic top_bottom_select,
  output logic status_freeze_enable,
  output logic [1:0] lock_rdata
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [sfph_pkg::PIN_CNT-1:0] pin_raw;
  logic [sfph_pkg::PIN_CNT-1:0] sync1_ff;
  logic [sfph_pkg::PIN_CNT-1:0] sync2_ff;
  logic sclk_d_ff;
  logic cs_n_d_ff;
  logic hold_n_d_ff;
  assign pin_raw = {serial_in_pin, wp_n, hold_n, cs_n, spi_clk};

  genvar gp;
  generate
    for (gp = 0; gp < sfph_pkg::PIN_CNT; gp++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (rst) begin
          sync1_ff[gp] <= (gp != sfph_pkg::PIN_SCLK);
          sync2_ff[gp] <= (gp != sfph_pkg::PIN_SCLK);
        end else if (ce) begin
          sync1_ff[gp] <= pin_raw[gp];
          sync2_ff[gp] <= sync1_ff[gp];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
      hold_n_d_ff <= 1'b1;
    end else if (ce) begin
      sclk_d_ff <= sync2_ff[sfph_pkg::PIN_SCLK];
      cs_n_d_ff <= sync2_ff[sfph_pkg::PIN_CS_N];
      hold_n_d_ff <= sync2_ff[sfph_pkg::PIN_HOLD_N];
    end
  end

  wire sclk_s = sync2_ff[sfph_pkg::PIN_SCLK];
  wire cs_n_s = sync2_ff[sfph_pkg::PIN_CS_N];
  wire hold_n_s = sync2_ff[sfph_pkg::PIN_HOLD_N];
  wire sclk_rise = sclk_s && !sclk_d_ff;
  wire sclk_fall = !sclk_s && sclk_d_ff;
  wire cs_rise = cs_n_s && !cs_n_d_ff;
  wire cs_fall = !cs_n_s && cs_n_d_ff;
  wire hold_fall = !hold_n_s && hold_n_d_ff;

  // ----------------------------------------
  // hold state machine
  // ----------------------------------------
  sfph_pkg::sfph_hold_e hs_ff;
  sfph_pkg::sfph_hold_e nxt_hs;
  logic hold_req_ff;
  wire selected = !cs_n_s && (hs_ff != sfph_pkg::HS_LOCKOUT);
  wire running = selected && (hs_ff == sfph_pkg::HS_RUN);

  always_comb begin
    nxt_hs = hs_ff;
    case (hs_ff)
      sfph_pkg::HS_RUN: begin
        if (selected && hold_req_ff && !hold_n_s && !sclk_s) begin
          nxt_hs = sfph_pkg::HS_HOLD;
        end
      end
      sfph_pkg::HS_HOLD: begin
        if (cs_n_s) begin
          nxt_hs = sfph_pkg::HS_LOCKOUT;
        end else if (hold_n_s && !sclk_s) begin
          nxt_hs = sfph_pkg::HS_RUN;
        end
      end
      sfph_pkg::HS_LOCKOUT: begin
        if (hold_n_s && cs_n_s) begin
          nxt_hs = sfph_pkg::HS_RUN;
        end
      end
      default: nxt_hs = sfph_pkg::HS_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hs_ff <= sfph_pkg::HS_RUN;
      hold_req_ff <= 1'b0;
    end else if (ce) begin
      hs_ff <= nxt_hs;
      if (hold_n_s || cs_n_s) begin
        hold_req_ff <= 1'b0;
      end else if (hold_fall && selected) begin
        hold_req_ff <= 1'b1;
      end
    end
  end
  assign hold_active = (hs_ff == sfph_pkg::HS_HOLD);

  // ----------------------------------------
  // bit counter and serial data
  // ----------------------------------------
  logic [sfph_pkg::BIT_CNT_W-1:0] bit_cnt_ff;
  logic rx_bit_ff;
  logic rx_strobe_ff;
  logic dout_ff;
  logic dout_oe_n_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bit_cnt_ff <= '0;
      rx_bit_ff <= 1'b0;
      rx_strobe_ff <= 1'b0;
      dout_ff <= 1'b0;
      dout_oe_n_ff <= 1'b1;
    end else if (ce) begin
      rx_strobe_ff <= 1'b0;
      dout_oe_n_ff <= !running;
      if (cs_fall || (hold_active && cs_n_s)) begin
        bit_cnt_ff <= '0;
      end else if (running && sclk_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
        rx_bit_ff <= sync2_ff[sfph_pkg::PIN_DIN];
        rx_strobe_ff <= 1'b1;
      end
      if (running && sclk_fall) begin
        dout_ff <= tx_bit;
      end
    end
  end
  assign serial_out_pin_o = dout_ff;
  assign serial_out_pin_oe_n = dout_oe_n_ff;
  assign rx_bit = rx_bit_ff;
  assign rx_strobe = rx_strobe_ff;

  // ----------------------------------------
  // command capture and protection checks
  // ----------------------------------------
  sfph_pkg::sfph_cmd_e cmd_ff;
  logic [sfph_pkg::SECTOR_W-1:0] sect_ff;
  logic cmd_pend_ff;
  logic arm_ff;
  logic busy_ff;
  logic sleep_ff;
  logic [sfph_pkg::PUW_CNT_W-1:0] puw_cnt_ff;
  logic puw_done_ff;
  logic [2:0] prot_ff;
  logic tb_ff;
  logic freeze_ff;
  logic [sfph_pkg::SECTOR_CNT-1:0] wlock_ff;
  logic [sfph_pkg::SECTOR_CNT-1:0] ldown_ff;
  logic go_ff;
  logic refuse_ff;
  logic [1:0] lock_rd_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_pend_ff <= 1'b0;
      cmd_ff <= sfph_pkg::CMD_NONE;
      sect_ff <= '0;
    end else if (ce) begin
      if (cs_fall || cs_rise) begin
        cmd_pend_ff <= 1'b0;
      end else if (cmd_valid && running) begin
        cmd_pend_ff <= 1'b1;
        cmd_ff <= cmd_code;
        sect_ff <= cmd_sector;
      end
    end
  end

  wire is_prog = (cmd_ff == sfph_pkg::CMD_OTP_WRITE) || (cmd_ff == sfph_pkg::CMD_PAGE_WRITE)
    || (cmd_ff == sfph_pkg::CMD_PAGE_WRITE_TWO_LANE);
  wire is_sect_wipe = (cmd_ff == sfph_pkg::CMD_BLOCK4K_WIPE) || (cmd_ff == sfph_pkg::CMD_BLOCK64K_WIPE);
  wire is_full_wipe = (cmd_ff == sfph_pkg::CMD_FULL_ARRAY_WIPE);
  wire is_status = (cmd_ff == sfph_pkg::CMD_STATUS_STORE);
  wire is_lock_st = (cmd_ff == sfph_pkg::CMD_LOCKREG_STORE);
  wire needs_mod8 = is_prog || is_sect_wipe || is_full_wipe || is_status;
  wire is_modify = needs_mod8 || is_lock_st;
  wire targets_sect = (is_prog && cmd_ff != sfph_pkg::CMD_OTP_WRITE) || is_sect_wipe;
  wire is_cycle = is_prog || is_sect_wipe || is_full_wipe || is_status;
  wire frame_end = cs_rise && hs_ff == sfph_pkg::HS_RUN && cmd_pend_ff;

  wire [7:0] range_cnt = sfph_pkg::RANGE_BASE << (prot_ff - 3'h1);
  wire [7:0] sect_ext = {1'b0, sect_ff};
  wire top_hit = sect_ext >= (8'(sfph_pkg::SECTOR_CNT) - range_cnt);
  wire bot_hit = sect_ext < range_cnt;
  wire range_hit = (prot_ff == sfph_pkg::PROT_ALL)
    || ((prot_ff != sfph_pkg::PROT_NONE) && (tb_ff ? bot_hit : top_hit));
  wire sect_prot = wlock_ff[sect_ff] || range_hit;
  wire status_frozen = freeze_ff && !sync2_ff[sfph_pkg::PIN_WP_N];

  wire bad_mod8 = needs_mod8 && (bit_cnt_ff != '0);
  wire bad_arm = is_modify && !arm_ff;
  wire bad_state = is_modify && (!puw_done_ff || busy_ff);
  wire bad_sleep = sleep_ff && (cmd_ff != sfph_pkg::CMD_WAKE);
  wire bad_prot = (targets_sect && sect_prot) || (is_full_wipe && prot_ff != sfph_pkg::PROT_NONE)
    || (is_status && status_frozen);
  wire accept = frame_end && !(bad_mod8 || bad_arm || bad_state || bad_sleep || bad_prot);
  wire reject = frame_end && !accept;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      go_ff <= 1'b0;
      refuse_ff <= 1'b0;
      arm_ff <= 1'b0;
      busy_ff <= 1'b0;
      sleep_ff <= 1'b0;
      puw_cnt_ff <= '0;
      puw_done_ff <= 1'b0;
      prot_ff <= sfph_pkg::PROT_RST;
      tb_ff <= 1'b0;
      freeze_ff <= 1'b0;
      lock_rd_ff <= sfph_pkg::LOCK_RST;
    end else if (ce) begin
      go_ff <= accept;
      refuse_ff <= reject;
      if (!puw_done_ff) begin
        puw_cnt_ff <= puw_cnt_ff + 1'b1;
        puw_done_ff <= (puw_cnt_ff == sfph_pkg::PUW_CNT_W'(PUW_CYCLES - 1));
      end
      if (accept && cmd_ff == sfph_pkg::CMD_WRITE_ARM) begin
        arm_ff <= 1'b1;
      end else if ((accept && (cmd_ff == sfph_pkg::CMD_WRITE_DISARM || is_lock_st)) || (busy_ff && op_done)) begin
        arm_ff <= 1'b0;
      end
      if (accept && is_cycle) begin
        busy_ff <= 1'b1;
      end else if (op_done) begin
        busy_ff <= 1'b0;
      end
      if (accept && cmd_ff == sfph_pkg::CMD_SLEEP) begin
        sleep_ff <= 1'b1;
      end else if (accept && cmd_ff == sfph_pkg::CMD_WAKE) begin
        sleep_ff <= 1'b0;
      end
      if (accept && is_status) begin
        prot_ff <= prot_size_wdata;
        tb_ff <= top_bottom_wdata;
        freeze_ff <= freeze_wdata;
      end
      if (accept && cmd_ff == sfph_pkg::CMD_LOCKREG_FETCH) begin
        lock_rd_ff <= {ldown_ff[sect_ff], wlock_ff[sect_ff]};
      end
    end
  end

  // ----------------------------------------
  // per-sector lock registers
  // ----------------------------------------
  genvar gs;
  generate
    for (gs = 0; gs < sfph_pkg::SECTOR_CNT; gs++) begin : g_lock
      always_ff @(posedge core_clk) begin
        if (rst) begin
          {ldown_ff[gs], wlock_ff[gs]} <= sfph_pkg::LOCK_RST;
        end else if (ce && accept && is_lock_st && sect_ff == sfph_pkg::SECTOR_W'(gs) && !ldown_ff[gs]) begin
          {ldown_ff[gs], wlock_ff[gs]} <= lock_wdata;
        end
      end
      lock_down_a: assert property (@(posedge core_clk) disable iff (rst)
        ldown_ff[gs] |=> ldown_ff[gs] && $stable(wlock_ff[gs]))
        else $error("locked-down sector bits changed");
    end
  endgenerate

  assign exec_go = go_ff;
  assign exec_refuse = refuse_ff;
  assign exec_cmd = cmd_ff;
  assign exec_sector = sect_ff;
  assign write_arm_latch = arm_ff;
  assign op_busy = busy_ff;
  assign deep_sleep = sleep_ff;
  assign powerup_done = puw_done_ff;
  assign prot_size = prot_ff;
  assign top_bottom_select = tb_ff;
  assign status_freeze_enable = freeze_ff;
  assign lock_rdata = lock_rd_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence hold_enter_s;
    ce && hs_ff == sfph_pkg::HS_RUN && selected && hold_req_ff && !hold_n_s && !sclk_s;
  endsequence
  sequence hold_leave_s;
    ce && hold_active && !cs_n_s && hold_n_s && !sclk_s;
  endsequence

  frame_mod8_a: assert property (ce && frame_end && needs_mod8 && bit_cnt_ff != '0 |=> !go_ff && refuse_ff)
    else $error("odd clock count accepted");
  arm_needed_a: assert property (ce && frame_end && is_modify && !arm_ff |=> refuse_ff)
    else $error("unarmed modify accepted");
  arm_clear_a: assert property (ce && busy_ff && op_done && !accept |=> !arm_ff)
    else $error("arm latch kept after completion");
  powerup_block_a: assert property (ce && frame_end && is_modify && !puw_done_ff |=> !go_ff)
    else $error("modify accepted before power-up wait");
  sleep_ignore_a: assert property (ce && frame_end && sleep_ff && is_modify |=> refuse_ff && $stable(prot_ff))
    else $error("modify accepted in deep sleep");
  sector_prot_a: assert property (ce && frame_end && targets_sect && sect_prot && !busy_ff |=> refuse_ff && !busy_ff)
    else $error("protected sector accepted");
  wipe_guard_a: assert property (ce && frame_end && is_full_wipe && prot_ff != 3'h0 |=> refuse_ff)
    else $error("full wipe accepted with range set");
  status_freeze_a: assert property (ce && status_frozen |=> $stable(prot_ff) && $stable(freeze_ff))
    else $error("frozen status changed");
  hold_start_a: assert property (hold_enter_s |=> hold_active ##1 (!ce || hold_active || cs_n_s || hold_n_s))
    else $error("hold not entered");
  hold_end_a: assert property (hold_leave_s |=> !hold_active)
    else $error("hold not left");
  hold_float_a: assert property (ce && hold_active |=> serial_out_pin_oe_n && !rx_strobe)
    else $error("pins active during hold");
  hold_desel_a: assert property (ce && hold_active && cs_n_s |=> hs_ff == sfph_pkg::HS_LOCKOUT && bit_cnt_ff == '0)
    else $error("deselect in hold did not reset");

endmodule : sfph_top

// ---- sim/sfph_host.sv ----
// spi host model driving the flash pins
`timescale 1ns/1ps
module sfph_host (
  // clock
  input wire logic core_clk,
  // flash pins
  output logic spi_clk,
  output logic cs_n,
  output logic hold_n,
  output logic wp_n,
  output logic serial_in_pin
);
  logic last_in;
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    wp_n = 1'b1;
    serial_in_pin = 1'b0;
    last_in = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic start();
    @(posedge core_clk);
    cs_n <= 1'b0;
    tick(6);
  endtask : start
  task automatic stop();
    @(posedge core_clk);
    cs_n <= 1'b1;
  endtask : stop
  task automatic bits(input int n);
    @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      serial_in_pin <= i[0] ^ i[1];
      last_in <= i[0] ^ i[1];
      spi_clk <= 1'b0;
      tick(13);
      spi_clk <= 1'b1;
      tick(12);
    end
    spi_clk <= 1'b0;
    tick(13);
  endtask : bits
  task automatic set_clk(input logic v);
    @(posedge core_clk);
    spi_clk <= v;
  endtask : set_clk
  task automatic set_hold(input logic v);
    @(posedge core_clk);
    hold_n <= v;
  endtask : set_hold
  task automatic set_wp(input logic v);
    @(posedge core_clk);
    wp_n <= v;
  endtask : set_wp
endmodule : sfph_host

// ---- sim/tb_top.sv ----
// self-checking bench for the flash protect and hold block
`timescale 1ns/1ps
module tb_top;
  localparam int PUW = 600;
  logic core_clk, rst, ce, spi_clk, cs_n, hold_n, wp_n, serial_in_pin, serial_out_pin_o, serial_out_pin_oe_n;
  logic cmd_valid, top_bottom_wdata, freeze_wdata, tx_bit, rx_bit, rx_strobe, op_done, exec_go, exec_refuse;
  logic write_arm_latch, op_busy, deep_sleep, powerup_done, hold_active, top_bottom_select, status_freeze_enable;
  logic [6:0] cmd_sector, exec_sector, last_s;
  logic [2:0] prot_size_wdata, prot_size;
  logic [1:0] lock_wdata, lock_rdata;
  sfph_pkg::sfph_cmd_e cmd_code, exec_cmd, last_c;
  sfph_pkg::sfph_cmd_e clr_q[$] = '{sfph_pkg::CMD_WRITE_DISARM, sfph_pkg::CMD_STATUS_STORE,
    sfph_pkg::CMD_LOCKREG_STORE, sfph_pkg::CMD_OTP_WRITE, sfph_pkg::CMD_PAGE_WRITE,
    sfph_pkg::CMD_PAGE_WRITE_TWO_LANE, sfph_pkg::CMD_BLOCK4K_WIPE, sfph_pkg::CMD_BLOCK64K_WIPE,
    sfph_pkg::CMD_FULL_ARRAY_WIPE};
  int miscompares, compares, cyc, res, cnt, p;

  sfph_top #(.PUW_CYCLES(PUW)) sfph_top_i (.core_clk, .rst, .ce, .spi_clk, .cs_n, .hold_n, .wp_n,
    .serial_in_pin, .serial_out_pin_o, .serial_out_pin_oe_n, .cmd_valid, .cmd_code, .cmd_sector,
    .lock_wdata, .prot_size_wdata, .top_bottom_wdata, .freeze_wdata, .tx_bit, .rx_bit, .rx_strobe,
    .op_done, .exec_go, .exec_refuse, .exec_cmd, .exec_sector, .write_arm_latch, .op_busy, .deep_sleep,
    .powerup_done, .hold_active, .prot_size, .top_bottom_select, .status_freeze_enable, .lock_rdata);
  sfph_host sfph_host_i (.core_clk, .spi_clk, .cs_n, .hold_n, .wp_n, .serial_in_pin);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic issue(input sfph_pkg::sfph_cmd_e c, input logic [6:0] s);
    last_c = c;
    last_s = s;
    sfph_host_i.start();
    cmd_code <= c;
    cmd_sector <= s;
    cmd_valid <= 1'b1;
    tick(1);
    cmd_valid <= 1'b0;
  endtask : issue
  task automatic finish(input int e);
    sfph_host_i.stop();
    res = 2;
    for (int i = 0; i < 8 && res == 2; i++) begin
      @(negedge core_clk);
      if (exec_go === 1'b1) res = 1;
      else if (exec_refuse === 1'b1) res = 0;
    end
    if (e < 3) chk("exec result", e[7:0], res[7:0]);
    if (res != 2) begin
      chk("exec_cmd", 8'(last_c), 8'(exec_cmd));
      chk("exec_sector", {1'b0, last_s}, {1'b0, exec_sector});
    end
    if (res == 1 && last_c inside {sfph_pkg::CMD_STATUS_STORE,
        [sfph_pkg::CMD_OTP_WRITE:sfph_pkg::CMD_FULL_ARRAY_WIPE]}) begin
      chk("op_busy", 8'h01, op_busy);
      tick(2);
      op_done <= 1'b1;
      tick(1);
      op_done <= 1'b0;
      settle(2);
      chk("op_busy", 8'h00, op_busy);
      chk("arm latch", 8'h00, write_arm_latch);
    end
    if (res == 1 && last_c inside {sfph_pkg::CMD_WRITE_DISARM, sfph_pkg::CMD_LOCKREG_STORE})
      chk("arm latch", 8'h00, write_arm_latch);
    tick(3);
  endtask : finish
  task automatic cmd(input sfph_pkg::sfph_cmd_e c, input logic [6:0] s, input int n, input int e);
    issue(c, s);
    sfph_host_i.bits(n);
    finish(e);
  endtask : cmd
  task automatic arm(input sfph_pkg::sfph_cmd_e c, input logic [6:0] s, input int e);
    cmd(sfph_pkg::CMD_WRITE_ARM, 7'h00, 8, 1);
    cmd(c, s, 8, e);
  endtask : arm
  task automatic wait_pu();
    for (int i = 0; i < PUW + 40 && powerup_done !== 1'b1; i++) settle(1);
    chk("powerup_done", 8'h01, powerup_done);
  endtask : wait_pu

  always @(negedge core_clk) begin
    // bit taken on the rising clock
    if (rx_strobe === 1'b1) chk("rx_bit", sfph_host_i.last_in, rx_bit);
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      close_out();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    tx_bit = 1'b0;
    op_done = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = sfph_pkg::CMD_NONE;
    cmd_sector = 7'h00;
    lock_wdata = 2'h0;
    prot_size_wdata = 3'h0;
    top_bottom_wdata = 1'b0;
    freeze_wdata = 1'b0;
    tick(10);
    rst <= 1'b0;
    settle(1);
    chk("arm latch", 8'h00, write_arm_latch);
    chk("oe_n", 8'h01, serial_out_pin_oe_n);
    chk("prot_size", 8'h00, prot_size);
    chk("powerup_done", 8'h00, powerup_done);
    cmd(sfph_pkg::CMD_WRITE_ARM, 7'h00, 8, 3);
    cmd(sfph_pkg::CMD_PAGE_WRITE, 7'h05, 8, 0);
    wait_pu();
    cmd(sfph_pkg::CMD_WRITE_DISARM, 7'h00, 8, 1);
    ce <= 1'b0;
    cmd(sfph_pkg::CMD_WRITE_ARM, 7'h00, 8, 2);
    chk("arm latch", 8'h00, write_arm_latch);
    ce <= 1'b1;
    cmd(sfph_pkg::CMD_PAGE_WRITE, 7'h05, 8, 0);
    cmd(sfph_pkg::CMD_WRITE_ARM, 7'h00, 8, 1);
    cmd(sfph_pkg::CMD_PAGE_WRITE, 7'h05, 9, 0);
    chk("arm latch", 8'h01, write_arm_latch);
    cmd(sfph_pkg::CMD_PAGE_WRITE, 7'h05, 16, 1);
    foreach (clr_q[i]) arm(clr_q[i], 7'h09, 1);
    $display("test guards done");
    lock_wdata <= 2'h1;
    arm(sfph_pkg::CMD_LOCKREG_STORE, 7'h05, 1);
    arm(sfph_pkg::CMD_PAGE_WRITE, 7'h05, 0);
    arm(sfph_pkg::CMD_PAGE_WRITE, 7'h06, 1);
    cmd(sfph_pkg::CMD_LOCKREG_FETCH, 7'h05, 8, 1);
    chk("lock_rdata", 8'h01, lock_rdata);
    lock_wdata <= 2'h3;
    arm(sfph_pkg::CMD_LOCKREG_STORE, 7'h05, 1);
    lock_wdata <= 2'h0;
    arm(sfph_pkg::CMD_LOCKREG_STORE, 7'h05, 1);
    cmd(sfph_pkg::CMD_LOCKREG_FETCH, 7'h05, 8, 1);
    chk("lock_rdata", 8'h03, lock_rdata);
    tick(1);
    rst <= 1'b1;
    tick(10);
    rst <= 1'b0;
    wait_pu();
    cmd(sfph_pkg::CMD_LOCKREG_FETCH, 7'h05, 8, 1);
    chk("lock_rdata", 8'h00, lock_rdata);
    arm(sfph_pkg::CMD_PAGE_WRITE, 7'h05, 1);
    $display("test locks done");
    for (int t = 0; t < 2; t++) begin
      for (int k = 1; k < 8; k++) begin
        cnt = (k == 7) ? 128 : (2 << (k - 1));
        prot_size_wdata <= k[2:0];
        top_bottom_wdata <= t[0];
        arm(sfph_pkg::CMD_STATUS_STORE, 7'h00, 1);
        chk("prot_size", k[7:0], prot_size);
        chk("top_bottom", t[7:0], top_bottom_select);
        p = t ? cnt - 1 : 128 - cnt;
        arm(sfph_pkg::CMD_PAGE_WRITE, p[6:0], 0);
        p = t ? cnt : 127 - cnt;
        if (k < 7) arm(sfph_pkg::CMD_PAGE_WRITE, p[6:0], 1);
      end
    end
    arm(sfph_pkg::CMD_FULL_ARRAY_WIPE, 7'h00, 0);
    freeze_wdata <= 1'b1;
    prot_size_wdata <= 3'h0;
    arm(sfph_pkg::CMD_STATUS_STORE, 7'h00, 1);
    chk("freeze", 8'h01, status_freeze_enable);
    sfph_host_i.set_wp(1'b0);
    prot_size_wdata <= 3'h2;
    arm(sfph_pkg::CMD_STATUS_STORE, 7'h00, 0);
    chk("prot_size", 8'h00, prot_size);
    sfph_host_i.set_wp(1'b1);
    freeze_wdata <= 1'b0;
    prot_size_wdata <= 3'h0;
    arm(sfph_pkg::CMD_STATUS_STORE, 7'h00, 1);
    $display("test ranges done");
    cmd(sfph_pkg::CMD_WRITE_ARM, 7'h00, 8, 1);
    cmd(sfph_pkg::CMD_SLEEP, 7'h00, 8, 1);
    chk("deep_sleep", 8'h01, deep_sleep);
    cmd(sfph_pkg::CMD_WRITE_ARM, 7'h00, 8, 0);
    cmd(sfph_pkg::CMD_PAGE_WRITE, 7'h00, 8, 0);
    cmd(sfph_pkg::CMD_WAKE, 7'h00, 8, 1);
    chk("deep_sleep", 8'h00, deep_sleep);
    chk("arm latch", 8'h01, write_arm_latch);
    cmd(sfph_pkg::CMD_WRITE_ARM, 7'h00, 8, 1);
    tx_bit <= 1'b1;
    issue(sfph_pkg::CMD_PAGE_WRITE, 7'h14);
    sfph_host_i.bits(4);
    settle(1);
    chk("oe_n", 8'h00, serial_out_pin_oe_n);
    chk("serial_out", 8'h01, serial_out_pin_o);
    sfph_host_i.set_clk(1'b1);
    tick(12);
    sfph_host_i.set_hold(1'b0);
    settle(8);
    chk("hold_active", 8'h00, hold_active);
    sfph_host_i.set_clk(1'b0);
    settle(8);
    chk("hold_active", 8'h01, hold_active);
    chk("oe_n", 8'h01, serial_out_pin_oe_n);
    tick(1);
    tx_bit <= 1'b0;
    sfph_host_i.bits(3);
    sfph_host_i.set_hold(1'b1);
    settle(8);
    chk("hold_active", 8'h00, hold_active);
    chk("serial_out", 8'h01, serial_out_pin_o);
    sfph_host_i.bits(3);
    finish(1);
    issue(sfph_pkg::CMD_WRITE_ARM, 7'h00);
    sfph_host_i.bits(2);
    sfph_host_i.set_hold(1'b0);
    settle(8);
    finish(2);
    sfph_host_i.set_hold(1'b1);
    tick(4);
    sfph_host_i.set_hold(1'b0);
    settle(8);
    chk("hold_active", 8'h00, hold_active);
    sfph_host_i.set_hold(1'b1);
    tick(4);
    cmd(sfph_pkg::CMD_WRITE_ARM, 7'h00, 8, 1);
    $display("test hold done");
    close_out();
  end
endmodule : tb_top
